// *** design/otp_pkg.sv ***
// Purpose: Shared constants for the nonvolatile programming sequencer.
// Assumes: 250 MHz clock; 8-bit register space behind a simple register port.
// Notes: Controller registers sit on APB at word offsets chosen here.
package otp_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned BURN_WAIT_MS = 20;
  localparam int unsigned BURN_WAIT_CYC = BURN_WAIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned BURN_TIME_CYC = 1000;
  localparam logic [7:0] CFG_FIRST = 8'h07;
  localparam logic [7:0] CFG_LAST = 8'h15;
  localparam int unsigned CFG_NUM = 15;
  localparam logic [7:0] CTRL_ADDR = 8'h16;
  localparam int unsigned CTRL_NOREFRESH_BIT = 6;
  localparam logic [7:0] STAT_ADDR = 8'h17;
  localparam int unsigned STAT_FAULT_BIT = 0;
  localparam logic [7:0] NV_BURN_TRIGGER = 8'h78;
  localparam logic [7:0] NV_RELOAD_TRIGGER = 8'h79;
  localparam logic [7:0] BURN_CODE = 8'ha5;
  localparam logic [7:0] RELOAD_CODE = 8'h5a;
  localparam logic [2:0] WRITE_BUDGET = 3'h6;
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_IRQ_STAT = 8'h08;
  localparam logic [7:0] APB_IRQ_CLR = 8'h0c;
  localparam logic [7:0] APB_IRQ_EN = 8'h10;
  localparam logic [7:0] APB_WDATA = 8'h14;
  localparam logic [7:0] APB_RDATA = 8'h18;
  localparam int unsigned CMD_PROGRAM = 0;
  localparam int unsigned CMD_WRITE = 1;
  localparam int unsigned CMD_READ = 2;
  localparam int unsigned CMD_MAX_TRIES = 4;
  localparam logic [3:0] MAX_TRIES = 4'h4;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_FAIL = 1;
endpackage

// *** design/otp_if.sv ***
// Purpose: Register port between the host controller and the device.
// Assumes: One clock; a write or read is one cycle, read data next cycle.
// Notes: None.
`timescale 1ns/1ps
interface otp_if (input wire logic clk);
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic prog_supply;
  modport dev (input wr_en, rd_en, addr, wdata, prog_supply, output rdata, rvalid);
  modport host (output wr_en, rd_en, addr, wdata, prog_supply, input rdata, rvalid);
endinterface

// *** design/otp_dev.sv ***
// Purpose: Device end: volatile config registers, burn and reload sequencing.
// Assumes: Host keeps the register port protocol; supply pin is asynchronous.
// Notes: The nonvolatile array is modelled with flip-flops.
`timescale 1ns/1ps
module otp_dev
  import otp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  otp_if.dev bus,
  output logic refresh_inhibit,
  output logic [2:0] writes_used
);
  typedef enum logic [1:0] {OTP_IDLE, OTP_BURN, OTP_RELOAD} otp_st_t;
  otp_st_t st_q;
  logic [7:0] vol_q [CFG_NUM];
  logic [7:0] nv_q [CFG_NUM];
  logic [7:0] ctrl_q;
  logic fault_q;
  logic [2:0] used_q;
  logic [15:0] cnt_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic sup_s1_q;
  logic sup_s2_q;
  wire in_cfg = bus.addr >= CFG_FIRST && bus.addr <= CFG_LAST;
  wire [3:0] idx = 4'(bus.addr - CFG_FIRST);
  wire burn_cmd = bus.wr_en && bus.addr == NV_BURN_TRIGGER && bus.wdata == BURN_CODE; // R2 R8
  wire reload_cmd = bus.wr_en && bus.addr == NV_RELOAD_TRIGGER && bus.wdata == RELOAD_CODE; // R5 R8
  wire budget_left = used_q < WRITE_BUDGET; // R7
  wire burn_done = st_q == OTP_BURN && cnt_q == 16'(BURN_TIME_CYC - 1);
  wire refresh_tick = st_q == OTP_IDLE && !ctrl_q[CTRL_NOREFRESH_BIT] && cnt_q == 16'hffff; // R6
  assign refresh_inhibit = ctrl_q[CTRL_NOREFRESH_BIT];
  assign writes_used = used_q;
  assign bus.rdata = rdata_q;
  assign bus.rvalid = rvalid_q;

  // ----------------------------------------
  // Sequencer and nonvolatile array.
  // ----------------------------------------
  always_ff @(posedge clk) begin
    sup_s1_q <= bus.prog_supply;
    sup_s2_q <= sup_s1_q;
    if (sys_rst) begin
      st_q <= OTP_IDLE;
      fault_q <= 1'b0;
      used_q <= 3'h0;
      cnt_q <= 16'h0;
    end else begin
      cnt_q <= 16'(cnt_q + 16'h1);
      case (st_q)
        OTP_IDLE: begin
          if (burn_cmd) begin
            cnt_q <= 16'h0;
            if (budget_left) begin
              st_q <= OTP_BURN; // R2
            end else begin
              fault_q <= 1'b1; // R4 R7
            end
          end else if (reload_cmd) begin
            st_q <= OTP_RELOAD; // R5
          end
        end
        OTP_BURN: begin
          if (burn_done) begin
            used_q <= 3'(used_q + 3'h1); // R7
            fault_q <= !sup_s2_q; // R4
            st_q <= OTP_IDLE;
          end
        end
        OTP_RELOAD: st_q <= OTP_IDLE;
        default: st_q <= OTP_IDLE;
      endcase
    end
  end

  for (genvar i = 0; i < CFG_NUM; i++) begin : g_cell
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        nv_q[i] <= 8'h0;
        vol_q[i] <= 8'h0;
      end else begin
        if (burn_done && sup_s2_q) begin
          nv_q[i] <= vol_q[i]; // R2
        end
        if (st_q == OTP_RELOAD || refresh_tick) begin
          vol_q[i] <= nv_q[i]; // R5 R6
        end else if (bus.wr_en && in_cfg && idx == 4'(i)) begin
          vol_q[i] <= bus.wdata;
        end
      end
    end
  end

  // ----------------------------------------
  // Control register and read path.
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= 8'h0;
      rdata_q <= 8'h0;
      rvalid_q <= 1'b0;
    end else begin
      if (bus.wr_en && bus.addr == CTRL_ADDR) begin
        ctrl_q <= bus.wdata; // R6
      end
      rvalid_q <= bus.rd_en;
      if (bus.rd_en) begin
        if (in_cfg) begin
          rdata_q <= vol_q[idx];
        end else if (bus.addr == CTRL_ADDR) begin
          rdata_q <= ctrl_q;
        end else if (bus.addr == STAT_ADDR) begin
          rdata_q <= {5'h0, st_q == OTP_BURN, 1'b0, fault_q}; // R4
        end else begin
          rdata_q <= 8'h0;
        end
      end
    end
  end
endmodule

// *** design/otp_host.sv ***
// Purpose: Host end: runs the burn, poll, retry, reload sequence from APB.
// Assumes: APB master of 32-bit data; device keeps its register port timing.
// Notes: Wait count is a parameter so a bench may shorten it.
`timescale 1ns/1ps
module otp_host
  import otp_pkg::*;
#(
  parameter int unsigned WAIT_CYC = BURN_WAIT_CYC
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  otp_if.host bus
);
  // How it works
  // (R1) Host loads config registers 0x07-0x15 first
  // (R2) Code 0xa5 at 0x78 starts burn
  // (R3) Host makes burned data parity even; this host adds no parity, data is burned as written
  // (R4) Wait 20 ms, read fault, retry
  // (R5) Code 0x5a at 0x79 reloads stored values
  // (R6) Inhibit bit stops refresh during programming
  // (R7) Only six burns allowed in lifetime; the device burn count used_q clears on sys_rst
  // (R8) Other values at command addresses ignored
  typedef enum logic [3:0] {H_IDLE, H_INHIBIT, H_BURN, H_WAIT, H_POLL, H_PWAIT,
    H_RELOAD, H_UNINHIBIT, H_WR, H_RD, H_RWAIT} hst_t;
  hst_t st_q;
  logic [2:0] cmd_q;
  logic [15:0] wdata_q;
  logic [7:0] rdata_q;
  logic [3:0] tries_q;
  logic [31:0] wait_q;
  logic busy_q;
  logic [1:0] irq_st_q;
  logic [1:0] irq_en_q;
  logic [31:0] prdata_q;
  wire wr_acc = psel && penable && pwrite;
  wire rd_acc = psel && penable && !pwrite;
  wire go = wr_acc && paddr == APB_CMD && !busy_q;
  wire ev_done = st_q == H_UNINHIBIT || (st_q == H_RWAIT && bus.rvalid) || st_q == H_WR;
  wire ev_fail = st_q == H_PWAIT && bus.rvalid && bus.rdata[0] && tries_q == MAX_TRIES;
  wire [1:0] ev = {ev_fail, ev_done && !ev_fail};
  wire known = paddr == APB_CMD || paddr == APB_STATUS || paddr == APB_IRQ_STAT ||
    paddr == APB_IRQ_CLR || paddr == APB_IRQ_EN || paddr == APB_WDATA || paddr == APB_RDATA;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known;
  assign prdata = prdata_q;
  assign irq = |(irq_st_q & irq_en_q);
  assign bus.prog_supply = st_q inside {H_BURN, H_WAIT, H_POLL, H_PWAIT};
  assign bus.wr_en = st_q inside {H_INHIBIT, H_BURN, H_RELOAD, H_UNINHIBIT, H_WR};
  assign bus.rd_en = st_q == H_POLL || st_q == H_RD;
  assign bus.addr = st_q == H_BURN ? NV_BURN_TRIGGER :
    st_q == H_RELOAD ? NV_RELOAD_TRIGGER :
    (st_q == H_POLL || st_q == H_PWAIT) ? STAT_ADDR :
    (st_q == H_INHIBIT || st_q == H_UNINHIBIT) ? CTRL_ADDR : wdata_q[15:8];
  assign bus.wdata = st_q == H_BURN ? BURN_CODE :
    st_q == H_RELOAD ? RELOAD_CODE :
    st_q == H_INHIBIT ? 8'(1 << CTRL_NOREFRESH_BIT) :
    st_q == H_UNINHIBIT ? 8'h0 : wdata_q[7:0];

  // ----------------------------------------
  // Command sequencer.
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= H_IDLE;
      busy_q <= 1'b0;
      tries_q <= 4'h0;
      wait_q <= 32'h0;
      rdata_q <= 8'h0;
    end else begin
      case (st_q)
        H_IDLE: begin
          if (go && pwdata[CMD_PROGRAM]) begin
            st_q <= H_INHIBIT; // R1
            busy_q <= 1'b1;
            tries_q <= 4'h0;
          end else if (go && pwdata[CMD_WRITE]) begin
            st_q <= H_WR;
            busy_q <= 1'b1;
          end else if (go && pwdata[CMD_READ]) begin
            st_q <= H_RD;
            busy_q <= 1'b1;
          end
        end
        H_INHIBIT: st_q <= H_BURN; // R6
        H_BURN: begin
          st_q <= H_WAIT; // R2
          tries_q <= 4'(tries_q + 4'h1);
          wait_q <= 32'h0;
        end
        H_WAIT: begin
          wait_q <= 32'(wait_q + 32'h1);
          if (wait_q == 32'(WAIT_CYC - 1)) begin
            st_q <= H_POLL; // R4
          end
        end
        H_POLL: st_q <= H_PWAIT;
        H_PWAIT: begin
          if (bus.rvalid) begin
            if (!bus.rdata[0]) begin
              st_q <= H_RELOAD; // R5
            end else if (tries_q == MAX_TRIES) begin
              st_q <= H_IDLE; // R7
              busy_q <= 1'b0;
            end else begin
              st_q <= H_BURN; // R4
            end
          end
        end
        H_RELOAD: st_q <= H_UNINHIBIT;
        H_UNINHIBIT: begin
          st_q <= H_IDLE; // R6
          busy_q <= 1'b0;
        end
        H_WR: begin
          st_q <= H_IDLE;
          busy_q <= 1'b0;
        end
        H_RD: st_q <= H_RWAIT;
        H_RWAIT: begin
          if (bus.rvalid) begin
            rdata_q <= bus.rdata;
            st_q <= H_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // APB registers and interrupt.
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdata_q <= 16'h0;
      irq_st_q <= 2'h0;
      irq_en_q <= 2'h0;
      prdata_q <= 32'h0;
    end else begin
      if (wr_acc && paddr == APB_WDATA && !busy_q) begin
        wdata_q <= pwdata[15:0];
      end
      if (wr_acc && paddr == APB_IRQ_EN) begin
        irq_en_q <= pwdata[1:0];
      end
      if (wr_acc && paddr == APB_IRQ_CLR) begin
        irq_st_q <= (irq_st_q & ~pwdata[1:0]) | ev;
      end else begin
        irq_st_q <= irq_st_q | ev;
      end
      if (psel && !penable && !pwrite) begin
        case (paddr)
          APB_STATUS: prdata_q <= {24'h0, tries_q, 3'h0, busy_q};
          APB_IRQ_STAT: prdata_q <= {30'h0, irq_st_q};
          APB_IRQ_EN: prdata_q <= {30'h0, irq_en_q};
          APB_WDATA: prdata_q <= {16'h0, wdata_q};
          APB_RDATA: prdata_q <= {24'h0, rdata_q};
          default: prdata_q <= 32'h0;
        endcase
      end
    end
  end
endmodule

// *** test/otp_asserts.sv ***
// Purpose: Checker on the register port between host and device.
// Assumes: WAIT_CYC equals the host instance value.
// Notes: Instantiated beside the interface.
`timescale 1ns/1ps
module otp_checker
  import otp_pkg::*;
#(
  parameter int unsigned WAIT_CYC = BURN_WAIT_CYC
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic prog_supply
);
  logic burn_w;
  logic reload_w;
  logic [31:0] gap_q;
  logic inhibit_q;
  logic poll_q;
  logic ok_q;
  assign burn_w = wr_en && addr == NV_BURN_TRIGGER && wdata == BURN_CODE;
  assign reload_w = wr_en && addr == NV_RELOAD_TRIGGER && wdata == RELOAD_CODE;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_q <= WAIT_CYC;
      inhibit_q <= 1'b0;
      poll_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      gap_q <= burn_w ? 32'h0 : (gap_q < WAIT_CYC ? gap_q + 32'h1 : gap_q);
      if (wr_en && addr == CTRL_ADDR) inhibit_q <= wdata[CTRL_NOREFRESH_BIT];
      if (rd_en) poll_q <= (addr == STAT_ADDR);
      if (burn_w) ok_q <= 1'b0;
      else if (rvalid && poll_q) ok_q <= !rdata[STAT_FAULT_BIT];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_read_answer: assert property (rd_en |=> rvalid) else $error("no answer to read");
  a_answer_cause: assert property (rvalid |-> $past(rd_en)) else $error("stray answer");
  a_single_op: assert property (!(wr_en && rd_en)) else $error("read and write at once");
  a_poll_wait: assert property (rd_en && addr == STAT_ADDR |-> gap_q >= WAIT_CYC - 1)
    else $error("fault polled too early");
  a_burn_gap: assert property (burn_w |-> gap_q >= WAIT_CYC - 1)
    else $error("burn repeated too early");
  a_inhibit_first: assert property (burn_w |-> inhibit_q) else $error("burn without inhibit");
  a_supply_burn: assert property (burn_w |-> prog_supply) else $error("burn without supply");
  a_reload_ok: assert property (reload_w |-> ok_q) else $error("reload without success");
  a_ctrl_restore: assert property (reload_w |-> ##[1:16] (wr_en && addr == CTRL_ADDR &&
    !wdata[CTRL_NOREFRESH_BIT])) else $error("inhibit not cleared");
  c_burn: cover property (burn_w);
  c_reload: cover property (reload_w);
  c_fault: cover property (rvalid && poll_q && rdata[STAT_FAULT_BIT]);
endmodule

// *** test/test_otp_programming_sequencer.sv ***
// Purpose: Drives the host over APB and checks the burn sequence end to end.
// Assumes: Host wait count shortened to 2000 cycles.
// Notes: None.
`timescale 1ns/1ps
module test_otp_programming_sequencer
  import otp_pkg::*;
;
  localparam int unsigned WC = 2000;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, inh, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] used;
  int bad_count, num_checks;
  otp_if bus (.clk(clk));
  otp_dev otp_dev_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus), .refresh_inhibit(inh),
    .writes_used(used));
  otp_host #(.WAIT_CYC(WC)) otp_host_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .bus(bus));
  otp_checker #(.WAIT_CYC(WC)) otp_checker_inst (.clk(clk), .sys_rst(sys_rst),
    .wr_en(bus.wr_en), .rd_en(bus.rd_en), .addr(bus.addr), .wdata(bus.wdata),
    .rdata(bus.rdata), .rvalid(bus.rvalid), .prog_supply(bus.prog_supply));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic idle();
    do apb(1'b0, APB_STATUS, 32'h0); while (r[0] !== 1'b0);
  endtask
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, APB_WDATA, {16'h0, a, d});
    apb(1'b1, APB_CMD, 32'h2);
    idle();
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, APB_IRQ_STAT, 32'h0);
    chk("irq_stat_rst", 32'h0, r);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, r);
    dev_wr(CFG_FIRST, 8'h3c);
    dev_wr(CFG_LAST, 8'hc3);
    apb(1'b1, APB_WDATA, {16'h0, CFG_FIRST, 8'h00});
    apb(1'b1, APB_CMD, 32'h4);
    idle();
    apb(1'b0, APB_RDATA, 32'h0);
    chk("cfg_read", 32'h3c, {24'h0, r[7:0]});
    dev_wr(NV_BURN_TRIGGER, RELOAD_CODE);
    dev_wr(NV_RELOAD_TRIGGER, BURN_CODE);
    chk("bad_code_used", 32'h0, {29'h0, used});
    apb(1'b1, APB_IRQ_EN, 32'h3);
    for (int i = 1; i <= 6; i++) begin
      apb(1'b1, APB_CMD, 32'h1);
      idle();
      apb(1'b0, APB_IRQ_STAT, 32'h0);
      chk("done_stat", 32'h1, r);
      chk("irq_set", 32'h1, {31'h0, irq});
      chk("used", i, {29'h0, used});
      chk("inhibit_off", 32'h0, {31'h0, inh});
      apb(1'b1, APB_IRQ_CLR, 32'h3);
      chk("irq_clr", 32'h0, {31'h0, irq});
    end
    apb(1'b1, APB_IRQ_EN, 32'h0);
    apb(1'b1, APB_CMD, 32'h1);
    idle();
    chk("tries", {28'h0, MAX_TRIES}, {28'h0, r[7:4]});
    apb(1'b0, APB_IRQ_STAT, 32'h0);
    chk("fail_stat", 32'h2, r);
    chk("irq_masked", 32'h0, {31'h0, irq});
    chk("used_cap", 32'h6, {29'h0, used});
    apb(1'b1, APB_IRQ_EN, 32'h3);
    chk("irq_unmask", 32'h1, {31'h0, irq});
    apb(1'b1, APB_IRQ_CLR, 32'h3);
    apb(1'b0, APB_IRQ_STAT, 32'h0);
    chk("irq_stat_clr", 32'h0, r);
    stop_test();
  end
endmodule
